// file: logic/fmt_decode_pkg.sv
// Package for the branch and memory format decoder.
// Assumes 32-bit instruction words with the opcode in the top byte.
package fmt_decode_pkg;

	// ==========================================================
	// Field positions
	localparam int OPC_LSB        = 24;
	localparam int OPC_W          = 8;
	localparam int FIRST_SOURCE_FIELD_LSB       = 19;
	localparam int SECOND_SOURCE_FIELD_LSB       = 14;
	localparam int REG_W          = 5;
	localparam int COMPARE_BRANCH_FORMAT_M1_BIT    = 13;
	localparam int DISP_LSB       = 2;
	localparam int COMPARE_BRANCH_FORMAT_DISP_W    = 11;
	localparam int CTRL_DISP_W    = 22;
	localparam int MEM_SUB_BIT    = 12;
	localparam int SHORT_MODE_LSB = 12;
	localparam int EXT_MODE_LSB   = 10;
	localparam int OFFSET_W       = 12;
	localparam int SCALE_LSB      = 7;
	localparam int SCALE_W        = 3;
	localparam int INDEX_LSB      = 0;

	// ==========================================================
	// Opcode classes and constants
	localparam logic [3:0] CLASS_CTRL_A  = 4'h0;
	localparam logic [3:0] CLASS_CTRL_B  = 4'h1;
	localparam logic [3:0] CLASS_COMPARE_BRANCH_FORMAT_A  = 4'h2;
	localparam logic [3:0] CLASS_COMPARE_BRANCH_FORMAT_B  = 4'h3;
	localparam logic [4:0] TEST_PREFIX   = 5'h04;
	localparam logic [7:0] RETURN_OPCODE = 8'h0a;
	localparam logic [1:0] SHORT_ABS     = 2'h0;
	localparam logic [1:0] SHORT_REG     = 2'h2;
	localparam logic [3:0] EXT_REG_IND   = 4'h4;
	localparam logic [3:0] EXT_IP_DISP   = 4'h5;
	localparam logic [3:0] EXT_RESERVED  = 4'h6;
	localparam logic [3:0] EXT_REG_INDEX = 4'h7;
	localparam logic [3:0] EXT_ABS_DISP  = 4'hc;
	localparam logic [3:0] EXT_REG_DISP  = 4'hd;
	localparam logic [3:0] EXT_IDX_DISP  = 4'he;
	localparam logic [3:0] EXT_FULL      = 4'hf;
	localparam logic [2:0] SCALE_MAX     = 3'h4;
	localparam logic [31:0] IP_DISP_BIAS = 32'h00000008;

	// ==========================================================
	// Reset values
	localparam logic RESET_VALID = 1'b0;
	localparam logic RESET_READY = 1'b1;

	typedef enum logic [2:0] {
		FMT_OTHER,
		FMT_CTRL,
		FMT_COMPARE_BRANCH_FORMAT,
		FMT_MEM_SHORT,
		FMT_MEM_EXT
	} fmt_e;

	typedef struct packed {
		fmt_e             format;
		logic [7:0]       opcode;
		logic             first_source_field_is_literal;
		logic [4:0]       first_source_field_reg;
		logic [31:0]      first_source_field_literal;
		logic [4:0]       second_source_field_reg;
		logic [4:0]       dst_reg;
		logic [31:0]      target;
		logic [31:0]      ea;
		logic             two_word;
		logic             fault_invalid;
	} decode_s;

endpackage

// file: logic/branch_target.sv
// Word displacement to branch target: ip plus four times the signed count.
// Assumes the ip is that of the branch instruction itself.
`timescale 1ns/100ps
`default_nettype none
module branch_target #(
	parameter int DISP_W = 11
) (
	input  wire logic [31:0]       ip,
	input  wire logic [DISP_W-1:0] disp,
	output logic      [31:0]       target
);
	logic [31:0] byte_disp;

	// Sign extend then scale by four
	assign byte_disp = {{(30-DISP_W){disp[DISP_W-1]}}, disp, 2'b00};
	assign target    = ip + byte_disp;
endmodule
`default_nettype wire

// file: logic/index_scaler.sv
// Index scaling by a power of two taken from the scale field.
// Assumes reserved scale codes may give any value.
`timescale 1ns/100ps
`default_nettype none
module index_scaler (
	input  wire logic [31:0] index_value,
	input  wire logic [2:0]  scale,
	output logic      [31:0] scaled
);
	// Reserved codes shift further; result is unspecified anyway
	assign scaled = index_value << scale;
endmodule
`default_nettype wire

// file: logic/fmt_decoder.sv
// Decoder for compare-branch, control-transfer and memory formats.
// Assumes fetch presents abase and index register values with the word
// and delivers a second displacement word when one is required.
// Notes on behaviour
// - Compare-branch opcode is an eight-bit field.
// - First source is register when mode bit 0, literal when 1; second always register.
// - Compare-branch target is ip plus four times signed word displacement.
// - Condition-test uses first source only, as destination; mode bit ignored.
// - Control-transfer: eight-bit opcode, 22-bit word displacement; return ignores it.
// - Memory word bit 12 clear picks short format, set picks extended.
// - Both memory formats have eight-bit opcode and one register field.
// - Register field names load destination or store data register group.
// - Short format offset is an unsigned byte offset.
// - Short mode 00 address is the offset alone; base ignored.
// - Short mode 10 address is base plus offset.
// - Mode 0100 is base; 0111 base plus scaled index; one word each.
// - Mode 0101 takes two words; address is ip plus displacement plus 8.
// - Modes 1100 to 1111 take two words with displacement based sums.
// - Mode 0110 raises invalid opcode fault.
// - Displacement is the signed 32-bit word after the instruction.
// - Scale codes 000 to 100 multiply index by 1, 2, 4, 8, 16.
// - Literal is five bits zero extended to 32.
`timescale 1ns/100ps
`default_nettype none
module fmt_decoder
	import fmt_decode_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        insn_valid,
	input  wire logic [31:0] insn_word,
	input  wire logic [31:0] insn_ip,
	input  wire logic [31:0] abase_data,
	input  wire logic [31:0] index_data,
	input  wire logic        disp_valid,
	input  wire logic [31:0] disp_word,
	output logic             insn_ready,
	output logic             out_valid,
	output decode_s          out
);

	// ==========================================================
	// Decode helpers
	function automatic fmt_e word_format(input logic [31:0] w);
		logic [3:0] cls;
		cls = w[28+:4];
		if (cls == CLASS_CTRL_A || cls == CLASS_CTRL_B)
			return FMT_CTRL;
		else if (cls == CLASS_COMPARE_BRANCH_FORMAT_A || cls == CLASS_COMPARE_BRANCH_FORMAT_B)
			return FMT_COMPARE_BRANCH_FORMAT;
		else if (w[31])
			return w[MEM_SUB_BIT] ? FMT_MEM_EXT : FMT_MEM_SHORT;
		else
			return FMT_OTHER;
	endfunction

	function automatic logic needs_disp(input logic [31:0] w);
		logic [3:0] m;
		m = w[EXT_MODE_LSB+:4];
		return (word_format(w) == FMT_MEM_EXT) &&
			(m == EXT_IP_DISP || m[3:2] == 2'b11);
	endfunction

	typedef enum logic [0:0] {
		ST_IDLE,
		ST_WAIT_DISP
	} state_e;

	state_e      state;
	logic [31:0] held_word;
	logic [31:0] held_ip;
	logic [31:0] held_base;
	logic [31:0] held_index;

	// ==========================================================
	// Current operands: live inputs when idle, held ones when waiting
	logic [31:0] cur_word;
	logic [31:0] cur_ip;
	logic [31:0] cur_base;
	logic [31:0] cur_index;
	fmt_e        cur_fmt;
	logic        cur_needs;
	logic        take_now;
	logic        take_first;
	logic        finish_disp;
	logic        is_test;

	assign cur_word    = (state == ST_IDLE) ? insn_word  : held_word;
	assign cur_ip      = (state == ST_IDLE) ? insn_ip    : held_ip;
	assign cur_base    = (state == ST_IDLE) ? abase_data : held_base;
	assign cur_index   = (state == ST_IDLE) ? index_data : held_index;
	assign cur_fmt     = word_format(cur_word);
	assign cur_needs   = needs_disp(cur_word);
	assign take_now    = (state == ST_IDLE) && insn_valid && !cur_needs;
	assign take_first  = (state == ST_IDLE) && insn_valid && cur_needs;
	assign finish_disp = (state == ST_WAIT_DISP) && disp_valid;
	assign is_test     = (cur_fmt == FMT_COMPARE_BRANCH_FORMAT) && (cur_word[27+:5] == TEST_PREFIX);

	// ==========================================================
	// Address arithmetic
	logic [31:0] compare_branch_format_target;
	logic [31:0] ctrl_target;
	logic [31:0] scaled_index;

	branch_target #(.DISP_W(COMPARE_BRANCH_FORMAT_DISP_W)) u_compare_branch_format_target (
		.ip     (cur_ip),
		.disp   (cur_word[DISP_LSB+:COMPARE_BRANCH_FORMAT_DISP_W]),
		.target (compare_branch_format_target)
	);

	branch_target #(.DISP_W(CTRL_DISP_W)) u_ctrl_target (
		.ip     (cur_ip),
		.disp   (cur_word[DISP_LSB+:CTRL_DISP_W]),
		.target (ctrl_target)
	);

	index_scaler u_scaler (
		.index_value (cur_index),
		.scale       (cur_word[SCALE_LSB+:SCALE_W]),
		.scaled      (scaled_index)
	);

	logic [31:0] offset_ext;
	logic [31:0] mem_ea;
	logic        mem_fault;
	logic [3:0]  ext_mode;

	// Offset is unsigned: zero extended, never sign extended
	assign offset_ext = {20'h00000, cur_word[0+:OFFSET_W]};
	assign ext_mode   = cur_word[EXT_MODE_LSB+:4];

	always_comb begin
		mem_ea    = 32'h00000000;
		mem_fault = 1'b0;
		if (cur_fmt == FMT_MEM_SHORT) begin
			case (cur_word[SHORT_MODE_LSB+:2])
				SHORT_ABS: mem_ea = offset_ext;
				SHORT_REG: mem_ea = cur_base + offset_ext;
				default:   mem_ea = offset_ext;
			endcase
		end else if (cur_fmt == FMT_MEM_EXT) begin
			// Displacement word is used as a full 32-bit signed value
			case (ext_mode)
				EXT_REG_IND:   mem_ea = cur_base;
				EXT_REG_INDEX: mem_ea = cur_base + scaled_index;
				EXT_IP_DISP:   mem_ea = cur_ip + disp_word + IP_DISP_BIAS;
				EXT_ABS_DISP:  mem_ea = disp_word;
				EXT_REG_DISP:  mem_ea = cur_base + disp_word;
				EXT_IDX_DISP:  mem_ea = scaled_index + disp_word;
				EXT_FULL:      mem_ea = cur_base + scaled_index + disp_word;
				default:       mem_fault = 1'b1;
			endcase
		end
	end

	// ==========================================================
	// Next decoded record
	decode_s next_out;

	always_comb begin
		next_out                 = '0;
		next_out.format          = cur_fmt;
		next_out.opcode          = cur_word[OPC_LSB+:OPC_W];
		next_out.second_source_field_reg        = cur_word[SECOND_SOURCE_FIELD_LSB+:REG_W];
		next_out.first_source_field_reg        = cur_word[FIRST_SOURCE_FIELD_LSB+:REG_W];
		next_out.two_word        = cur_needs;
		case (cur_fmt)
			FMT_COMPARE_BRANCH_FORMAT: begin
				next_out.target = compare_branch_format_target;
				if (is_test) begin
					// Only first field used, as the result register
					next_out.dst_reg = cur_word[FIRST_SOURCE_FIELD_LSB+:REG_W];
				end else if (cur_word[COMPARE_BRANCH_FORMAT_M1_BIT]) begin
					next_out.first_source_field_is_literal = 1'b1;
					next_out.first_source_field_literal = {27'h0000000, cur_word[FIRST_SOURCE_FIELD_LSB+:REG_W]};
				end
			end
			FMT_CTRL: begin
				if (cur_word[OPC_LSB+:OPC_W] != RETURN_OPCODE)
					next_out.target = ctrl_target;
			end
			FMT_MEM_SHORT, FMT_MEM_EXT: begin
				// Load destination or first of a group; store data source
				next_out.dst_reg       = cur_word[FIRST_SOURCE_FIELD_LSB+:REG_W];
				next_out.ea            = mem_ea;
				next_out.fault_invalid = mem_fault;
			end
			default: begin
				next_out.target = 32'h00000000;
			end
		endcase
	end

	// ==========================================================
	// Sequencing of one- and two-word instructions
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE: begin
					if (take_first)
						state <= ST_WAIT_DISP;
				end
				ST_WAIT_DISP: begin
					if (disp_valid)
						state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			held_word  <= 32'h00000000;
			held_ip    <= 32'h00000000;
			held_base  <= 32'h00000000;
			held_index <= 32'h00000000;
		end else if (take_first) begin
			held_word  <= insn_word;
			held_ip    <= insn_ip;
			held_base  <= abase_data;
			held_index <= index_data;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			insn_ready <= RESET_READY;
		end else begin
			insn_ready <= !(take_first || ((state == ST_WAIT_DISP) && !disp_valid));
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			out_valid <= RESET_VALID;
			out       <= '0;
		end else begin
			out_valid <= take_now || finish_disp;
			if (take_now || finish_disp)
				out <= next_out;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	sequence s_first_word;
		take_first;
	endsequence

	sequence s_disp_arrives;
		(state == ST_WAIT_DISP) && disp_valid;
	endsequence

	property p_opcode;
		take_now |=> out_valid && (out.opcode == $past(insn_word[31:24]));
	endproperty
	a_opcode: assert property (p_opcode) else $error("opcode not taken from top byte");

	property p_literal;
		take_now && (cur_fmt == FMT_COMPARE_BRANCH_FORMAT) && !is_test && insn_word[13] |=>
			out.first_source_field_is_literal && (out.first_source_field_literal == {27'h0, $past(insn_word[23:19])});
	endproperty
	a_literal: assert property (p_literal) else $error("literal source wrong");

	property p_compare_branch_format_target;
		take_now && (cur_fmt == FMT_COMPARE_BRANCH_FORMAT) |=> out.target ==
			$past(insn_ip) + {{19{$past(insn_word[12])}}, $past(insn_word[12:2]), 2'b00};
	endproperty
	a_compare_branch_format_target: assert property (p_compare_branch_format_target) else $error("branch target wrong");

	property p_test_dst;
		take_now && is_test |=> !out.first_source_field_is_literal && (out.dst_reg == $past(insn_word[23:19]));
	endproperty
	a_test_dst: assert property (p_test_dst) else $error("test destination wrong");

	property p_ret_target;
		take_now && (cur_fmt == FMT_CTRL) && (insn_word[31:24] == RETURN_OPCODE) |=>
			out.target == 32'h00000000;
	endproperty
	a_ret_target: assert property (p_ret_target) else $error("return used displacement");

	property p_subformat;
		take_now && insn_word[31] && (cur_fmt != FMT_OTHER) |=>
			(out.format == FMT_MEM_EXT) == $past(insn_word[12]);
	endproperty
	a_subformat: assert property (p_subformat) else $error("memory sub-format wrong");

	property p_abs_offset;
		take_now && (cur_fmt == FMT_MEM_SHORT) && (insn_word[13] == 1'b0) |=>
			out.ea == {20'h0, $past(insn_word[11:0])};
	endproperty
	a_abs_offset: assert property (p_abs_offset) else $error("absolute offset wrong");

	property p_reg_offset;
		take_now && (cur_fmt == FMT_MEM_SHORT) && insn_word[13] |=>
			out.ea == $past(abase_data) + {20'h0, $past(insn_word[11:0])};
	endproperty
	a_reg_offset: assert property (p_reg_offset) else $error("base plus offset wrong");

	property p_two_word;
		s_first_word |=> !out_valid ##0 !insn_ready;
	endproperty
	a_two_word: assert property (p_two_word) else $error("two-word instruction not held");

	property p_disp_done;
		s_disp_arrives |=> out_valid && out.two_word ##1 insn_ready;
	endproperty
	a_disp_done: assert property (p_disp_done) else $error("second word not completed");

	property p_reserved;
		take_now && (cur_fmt == FMT_MEM_EXT) && (insn_word[13:10] == EXT_RESERVED) |=>
			out_valid && out.fault_invalid;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved mode did not fault");

	property p_scale;
		(cur_word[9:7] <= SCALE_MAX) |-> scaled_index == cur_index * (32'h1 << cur_word[9:7]);
	endproperty
	a_scale: assert property (p_scale) else $error("index scale wrong");

endmodule
`default_nettype wire

// file: tb/fetch_model.sv
// Fetch-side model that hands over the displacement word of two-word instructions.
// Assumes the decoder drops insn_ready while it waits for the second word.
`timescale 1ns/100ps
`default_nettype none
module fetch_model (
	input  wire logic        sys_clk,
	input  wire logic        sys_rst,
	input  wire logic        insn_ready,
	input  wire logic [31:0] disp_in,
	input  wire logic [3:0]  gap,
	output logic             disp_valid,
	output logic [31:0]      disp_word
);
	// ==========================================================
	// Delivery after a programmable gap
	logic       prev_ready;
	logic       armed;
	logic [3:0] cnt;
	logic       go;

	assign go = armed || (prev_ready && !insn_ready);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			prev_ready <= 1'b1;
			armed      <= 1'b0;
			cnt        <= 4'h0;
			disp_valid <= 1'b0;
			disp_word  <= 32'h0;
		end else begin
			prev_ready <= insn_ready;
			if (disp_valid) begin
				// Word released: line no longer shows the last value
				disp_valid <= 1'b0;
				disp_word  <= ~disp_word;
			end else if (go && cnt == gap) begin
				// Signed word right after the instruction word
				disp_valid <= 1'b1;
				disp_word  <= disp_in;
				armed      <= 1'b0;
				cnt        <= 4'h0;
			end else if (go) begin
				armed      <= 1'b1;
				cnt        <= cnt + 4'h1;
				disp_word  <= ~disp_word;
			end else begin
				disp_word  <= ~disp_word;
			end
		end
	end
endmodule
`default_nettype wire

// file: tb/fmt_decoder_tb.sv
// Self-checking bench for the format decoder, random words plus corner cases.
// Assumes the package and design files are compiled before this file.
`timescale 1ns/100ps
`default_nettype none
module fmt_decoder_tb
	import fmt_decode_pkg::*;
;
	logic        sys_clk;
	logic        sys_rst;
	logic        insn_valid;
	logic        disp_valid;
	logic        insn_ready;
	logic        out_valid;
	logic [31:0] insn_word;
	logic [31:0] insn_ip;
	logic [31:0] abase_data;
	logic [31:0] index_data;
	logic [31:0] disp_word;
	logic [31:0] disp_in;
	logic [3:0]  gap;
	decode_s     out;
	int          error_cnt;
	int          cmp_count;
	int          cycles;

	always #20 sys_clk = ~sys_clk;

	fmt_decoder dut (
		.sys_clk    (sys_clk),
		.sys_rst    (sys_rst),
		.insn_valid (insn_valid),
		.insn_word  (insn_word),
		.insn_ip    (insn_ip),
		.abase_data (abase_data),
		.index_data (index_data),
		.disp_valid (disp_valid),
		.disp_word  (disp_word),
		.insn_ready (insn_ready),
		.out_valid  (out_valid),
		.out        (out)
	);

	fetch_model fetch (
		.sys_clk    (sys_clk),
		.sys_rst    (sys_rst),
		.insn_ready (insn_ready),
		.disp_in    (disp_in),
		.gap        (gap),
		.disp_valid (disp_valid),
		.disp_word  (disp_word)
	);

	// ==========================================================
	// Reporting
	task end_sim;
		if (error_cnt == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task cmp(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			end_sim();
		end
	end

	// ==========================================================
	// Expected decode
	function automatic decode_s predict(input logic [31:0] w, ip, ab, ix, dw);
		decode_s     e;
		logic [31:0] si;
		e = '0;
		si = ix << w[9:7];
		e.opcode = w[31:24];
		e.first_source_field_reg = w[23:19];
		e.second_source_field_reg = w[18:14];
		e.dst_reg = w[23:19];
		e.first_source_field_is_literal = w[13];
		e.first_source_field_literal = w[13] ? {27'h0, w[23:19]} : 32'h0;
		e.target = ip + {{19{w[12]}}, w[12:2], 2'b00};
		case (w[31:28])
			4'h0, 4'h1: begin
				e.format = FMT_CTRL;
				e.target = ip + {{8{w[23]}}, w[23:2], 2'b00};
				if (w[31:24] == RETURN_OPCODE)
					e.target = 32'h0;
			end
			4'h2, 4'h3: e.format = FMT_COMPARE_BRANCH_FORMAT;
			4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf: begin
				if (!w[12]) begin
					e.format = FMT_MEM_SHORT;
					e.ea = {20'h0, w[11:0]} + (w[13] ? ab : 32'h0);
				end else begin
					e.format = FMT_MEM_EXT;
					e.two_word = w[13] || w[13:10] == 4'h5;
					e.fault_invalid = w[13:10] == 4'h6;
					case (w[13:10])
						4'h4: e.ea = ab;
						4'h5: e.ea = ip + dw + 32'h8;
						4'h7: e.ea = ab + si;
						4'hc: e.ea = dw;
						4'hd: e.ea = ab + dw;
						4'he: e.ea = si + dw;
						4'hf: e.ea = ab + si + dw;
						default: e.ea = 32'h0;
					endcase
				end
			end
			default: e.format = FMT_OTHER;
		endcase
		return e;
	endfunction

	// ==========================================================
	// One instruction through the decoder
	task run(input logic [31:0] w, ip, ab, ix, dw, input logic [3:0] g);
		decode_s e;
		int      n;
		e = predict(w, ip, ab, ix, dw);
		@(posedge sys_clk);
		insn_valid <= 1'b1;
		insn_word  <= w;
		insn_ip    <= ip;
		abase_data <= ab;
		index_data <= ix;
		disp_in    <= dw;
		gap        <= g;
		@(posedge sys_clk);
		insn_valid <= 1'b0;
		insn_word  <= ~w;
		insn_ip    <= ~ip;
		abase_data <= ~ab;
		index_data <= ~ix;
		n = 0;
		#1;
		while (out_valid !== 1'b1 && n < 30) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		cmp(32'(out_valid), 32'h1);
		cmp(32'(out.format), 32'(e.format));
		cmp(32'(out.opcode), 32'(e.opcode));
		case (e.format)
			FMT_CTRL: cmp(out.target, e.target);
			FMT_COMPARE_BRANCH_FORMAT: begin
				if (w[31:27] == TEST_PREFIX) begin
					cmp(32'(out.dst_reg), 32'(e.dst_reg));
				end else begin
					cmp(out.target, e.target);
					cmp(32'(out.second_source_field_reg), 32'(e.second_source_field_reg));
					cmp(32'(out.first_source_field_is_literal), 32'(e.first_source_field_is_literal));
					cmp(out.first_source_field_literal, e.first_source_field_literal);
					if (!w[13])
						cmp(32'(out.first_source_field_reg), 32'(e.first_source_field_reg));
				end
			end
			FMT_MEM_SHORT, FMT_MEM_EXT: begin
				cmp(32'(out.dst_reg), 32'(e.dst_reg));
				cmp(out.ea, e.ea);
				cmp(32'(out.two_word), 32'(e.two_word));
				cmp(32'(out.fault_invalid), 32'(e.fault_invalid));
			end
			default: ;
		endcase
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		logic [31:0] w;
		sys_clk = 1'b0;
		sys_rst = 1'b1;
		insn_valid = 1'b0;
		insn_word = 32'h0;
		insn_ip = 32'h0;
		abase_data = 32'h0;
		index_data = 32'h0;
		disp_in = 32'h0;
		gap = 4'h0;
		error_cnt = 0;
		cmp_count = 0;
		cycles = 0;
		void'($urandom(63833));
		repeat (8) @(posedge sys_clk);
		sys_rst <= 1'b0;
		// Corner cases: displacement extremes, return, condition test, offset limits
		run(32'h0a7ffffc, 32'h00001000, 32'h0, 32'h0, 32'h0, 4'h0);
		run(32'h08800000, 32'h00400000, 32'h0, 32'h0, 32'h0, 4'h0);
		run(32'h087ffffc, 32'h00000100, 32'h0, 32'h0, 32'h0, 4'h0);
		run(32'h3a001000, 32'h00002000, 32'h0, 32'h0, 32'h0, 4'h0);
		run(32'h3aff6ffc, 32'h00002000, 32'h0, 32'h0, 32'h0, 4'h0);
		run(32'h20f82000, 32'h00000040, 32'h0, 32'h0, 32'h0, 4'h0);
		run(32'h80f80fff, 32'h0, 32'hdeadbeef, 32'h0, 32'h0, 4'h0);
		run(32'h90803fff, 32'h0, 32'hfffff800, 32'h0, 32'h0, 4'h0);
		run(32'h40000000, 32'h0, 32'h0, 32'h0, 32'h0, 4'h0);
		run(32'h94391380, 32'h0, 32'h00008000, 32'h5, 32'h0, 4'h0);
		// Every extended mode with every defined scale, fast and slow fetch
		for (int m = 4; m < 16; m++) begin
			for (int s = 0; s < 5; s++) begin
				if (m[2])
					run({8'h94, 5'h07, 5'h03, m[3:0], s[2:0], 2'b00, 5'h02}, $urandom,
					    $urandom, $urandom, 32'h80000000 >> s, s[3:0]);
			end
		end
		// Random words across the formats
		repeat (300) begin
			w = $urandom;
			case ($urandom % 4)
				0: w[31:29] = 3'h0;
				1: w[31:29] = 3'h1;
				2: begin
					w[31] = 1'b1;
					w[12] = 1'b0;
				end
				default: begin
					w[31] = 1'b1;
					w[12] = 1'b1;
					w[9:7] = 3'($urandom % 5);
				end
			endcase
			run(w, $urandom, $urandom, $urandom, $urandom, 4'($urandom % 6));
		end
		end_sim();
	end
endmodule
`default_nettype wire
